//--- dv/rcc_ctrl1_monitor.sv
// Checker for control register one and its interrupt outputs
module rcc_ctrl1_monitor
  import rcc_pkg::*;
(
  // Clock, resets and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        manual_reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupt requests
  input wire logic        carry_irq,
  input wire logic        alarm_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr1;
  assign acc = psel && penable && pready;
  assign wr1 = acc && pwrite && paddr == RCC_OFF_CTRL1 && pstrb[0];
  a_ready_access: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_reserved_zero: assert property (
    acc && !pwrite && paddr == RCC_OFF_CTRL1
    |-> prdata[31:8] == 24'h0 && prdata[6:5] == 2'h0 && prdata[2:1] == 2'h0)
    else $error("reserved bits not zero");
  a_unmapped_err: assert property (acc && paddr[11:4] != 8'h0 |-> pslverr)
    else $error("no error on unmapped access");
  a_carry_set: assert property (
    wr1 && pwdata[7] && pwdata[4] && !manual_reset |=> carry_irq)
    else $error("carry write did not set");
  a_carry_gate: assert property (wr1 && !pwdata[4] |=> !carry_irq)
    else $error("carry request while disabled");
  a_alarm_gate: assert property (wr1 && !pwdata[3] |=> !alarm_irq)
    else $error("alarm request while disabled");
  a_irq_hold: assert property (
    (carry_irq || alarm_irq) && !wr1 && !manual_reset
    |=> $past(carry_irq) == carry_irq || !$past(carry_irq))
    else $error("carry request dropped");
  a_alarm_hold: assert property (
    alarm_irq && !wr1 && !manual_reset |=> alarm_irq)
    else $error("alarm request dropped");
  a_manual_clear: assert property (
    manual_reset |=> !carry_irq && !alarm_irq)
    else $error("manual reset left a request");
  c_carry: cover property ($rose(carry_irq));
  c_alarm: cover property ($rose(alarm_irq));
  c_err: cover property (acc && pslverr);
endmodule

bind rcc_ctrl1 rcc_ctrl1_monitor u_rcc_ctrl1_monitor (.pclk(pclk),
  .presetn(presetn), .manual_reset(manual_reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .carry_irq(carry_irq), .alarm_irq(alarm_irq));

//--- dv/testbench.sv
// Self-checking bench for control register one
module testbench
  import rcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        manual_reset = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  rcc_cnt_s    cnt = '0;
  rcc_cal_s    cal = '0;
  rcc_alarm_s  alarm = '0;
  logic        carry_irq;
  logic        alarm_irq;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          err_total = 0;
  int          num_checks = 0;
  int          cyc = 0;
  rcc_ctrl1 u_rcc_ctrl1 (.pclk(pclk), .presetn(presetn),
    .manual_reset(manual_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cnt(cnt),
    .cal(cal), .alarm(alarm), .carry_irq(carry_irq),
    .alarm_irq(alarm_irq), .irq(irq));
  initial forever #5 pclk = ~pclk;
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Interrupt pins settle after the edge, so look at the falling edge
  task automatic irqs(input logic [2:0] e);
    @(negedge pclk);
    chk({29'h0, carry_irq, alarm_irq, irq}, {29'h0, e});
  endtask
  task automatic tick(input logic [3:0] c);
    @(posedge pclk);
    cnt <= c;
    @(posedge pclk);
    cnt <= '0;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rdc(RCC_OFF_CTRL1, 32'h0);
    irqs(3'b000);
    $display("test reset done");
    wr(RCC_OFF_CTRL1, 32'h99);
    rdc(RCC_OFF_CTRL1, 32'h98);
    irqs(3'b100);
    wr(RCC_OFF_CTRL1, 32'h18);
    rdc(RCC_OFF_CTRL1, 32'h18);
    irqs(3'b000);
    for (int i = 0; i < 2; i++) begin
      tick(i ? 4'h4 : 4'h8);
      rdc(RCC_OFF_CTRL1, 32'h98);
      irqs(3'b100);
      wr(RCC_OFF_CTRL1, 32'h18);
    end
    $display("test carry done");
    wr(RCC_OFF_ISTAT, 32'h7);
    rdc(RCC_OFF_ISTAT, 32'h0);
    tick(4'ha);
    rdc(RCC_OFF_ISTAT, 32'h5);
    rdc(RCC_OFF_CTRL1, 32'h98);
    wr(RCC_OFF_IMASK, 32'h5);
    irqs(3'b101);
    wr(RCC_OFF_IMASK, 32'h2);
    rdc(RCC_OFF_IMASK, 32'h2);
    irqs(3'b100);
    wr(RCC_OFF_IMASK, 32'h1);
    wr(RCC_OFF_ISTAT, 32'h1);
    rdc(RCC_OFF_ISTAT, 32'h4);
    wr(RCC_OFF_CTRL1, 32'h18);
    wr(RCC_OFF_ISTAT, 32'h4);
    $display("test events done");
    alarm.value.second <= 8'h30;
    alarm.value.year <= 16'h1999;
    alarm.alarm_field_enable <= 6'h01;
    cal.second <= 8'h29;
    cal.year <= 16'h2024;
    rdc(RCC_OFF_MATCH, 32'h0);
    cal.second <= 8'h30;
    rdc(RCC_OFF_MATCH, 32'h1);
    rdc(RCC_OFF_CTRL1, 32'h19);
    rdc(RCC_OFF_ISTAT, 32'h2);
    irqs(3'b010);
    wr(RCC_OFF_CTRL1, 32'h19);
    rdc(RCC_OFF_CTRL1, 32'h19);
    wr(RCC_OFF_CTRL1, 32'h18);
    rdc(RCC_OFF_CTRL1, 32'h18);
    irqs(3'b000);
    wr(RCC_OFF_CTRL1, 32'h10);
    alarm.year_alarm_enable <= 1'b1;
    rdc(RCC_OFF_MATCH, 32'h0);
    alarm.value.year <= 16'h2024;
    rdc(RCC_OFF_CTRL1, 32'h11);
    irqs(3'b000);
    $display("test alarm done");
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // Both requests up so that the manual reset has something to clear
    wr(RCC_OFF_CTRL1, 32'h99);
    irqs(3'b110);
    @(posedge pclk);
    manual_reset <= 1'b1;
    @(posedge pclk);
    manual_reset <= 1'b0;
    rdc(RCC_OFF_CTRL1, 32'h0);
    irqs(3'b000);
    $display("test unmapped and manual reset done");
    tally_and_finish();
  end
endmodule

//--- shared/rcc_pkg.sv
// Package for the RTC carry and alarm flag control block
package rcc_pkg;

  // Register byte addresses on the APB
  localparam logic [11:0] RCC_OFF_CTRL1 = 12'h000;
  localparam logic [11:0] RCC_OFF_ISTAT = 12'h004;
  localparam logic [11:0] RCC_OFF_IMASK = 12'h008;
  localparam logic [11:0] RCC_OFF_MATCH = 12'h00c;

  // Field positions of rtc_control_one
  localparam int RCC_BIT_CF  = 7;
  localparam int RCC_BIT_CIE = 4;
  localparam int RCC_BIT_AIE = 3;
  localparam int RCC_BIT_AF  = 0;

  // Field positions of the event status and mask registers
  localparam int RCC_EV_CARRY = 0;
  localparam int RCC_EV_ALARM = 1;
  localparam int RCC_EV_RDCOL = 2;
  localparam int RCC_EV_W     = 3;

  // Reset values
  localparam logic [7:0]          RCC_CTRL1_RST = 8'h00;
  localparam logic [RCC_EV_W-1:0] RCC_EV_RST    = 3'h0;

  // Number of alarm fields enabled through alarm_field_enable; year has its own enable bit
  localparam int RCC_NFIELD = 6;

  // Clock and calendar counter values, BCD coded
  typedef struct packed {
    logic [15:0] year;
    logic [7:0]  month;
    logic [7:0]  day;
    logic [7:0]  week;
    logic [7:0]  hour;
    logic [7:0]  minute;
    logic [7:0]  second;
  } rcc_cal_s;

  // Alarm settings with per field enables
  typedef struct packed {
    rcc_cal_s                value;
    logic [RCC_NFIELD-1:0]   alarm_field_enable;
    logic                    year_alarm_enable;
  } rcc_alarm_s;

  // Count-up pulses and counter reads from the clock counters
  typedef struct packed {
    logic subsecond_tick;
    logic seconds_tick;
    logic subsecond_read;
    logic seconds_read;
  } rcc_cnt_s;

  // Control register one
  typedef struct packed {
    logic carry_flag;
    logic carry_irq_enable;
    logic alarm_irq_enable;
    logic alarm_flag;
  } rcc_ctrl1_s;

endpackage

//--- src/rcc_alarm_match.sv
// Alarm comparator over the enabled clock and calendar fields
module rcc_alarm_match
  import rcc_pkg::*;
(
  // Current time and alarm setting
  input  rcc_cal_s   cal,
  input  rcc_alarm_s alarm,
  // Comparison result
  output logic       match
);

  logic [RCC_NFIELD:0] hit;

  always_comb begin
    // A field left out of the comparison counts as a hit
    hit[0] = !alarm.alarm_field_enable[0] ||
             (cal.second == alarm.value.second);             // R14
    hit[1] = !alarm.alarm_field_enable[1] ||
             (cal.minute == alarm.value.minute);             // R14
    hit[2] = !alarm.alarm_field_enable[2] ||
             (cal.hour == alarm.value.hour);                 // R14
    hit[3] = !alarm.alarm_field_enable[3] ||
             (cal.week == alarm.value.week);                 // R14
    hit[4] = !alarm.alarm_field_enable[4] ||
             (cal.day == alarm.value.day);                   // R14
    hit[5] = !alarm.alarm_field_enable[5] ||
             (cal.month == alarm.value.month);               // R14
    hit[6] = !alarm.year_alarm_enable ||
             (cal.year == alarm.value.year);                 // R11
    // With nothing enabled there is no alarm
    match = (&hit) &&
            ((|alarm.alarm_field_enable) || alarm.year_alarm_enable);
  end

endmodule

//--- src/rcc_carry_detect.sv
// Carry event detection for the subsecond and seconds counters
module rcc_carry_detect
  import rcc_pkg::*;
(
  // Counter activity
  input  rcc_cnt_s cnt,
  // Events
  output logic     carry_evt,
  output logic     carry_in_read
);

  always_comb begin
    carry_evt     = cnt.subsecond_tick || cnt.seconds_tick;         // R5
    carry_in_read = carry_evt &&
                    (cnt.subsecond_read || cnt.seconds_read);      // R6
  end

endmodule

//--- src/rcc_ctrl1.sv
// RTC control register one with carry and alarm flags, APB slave
// Contract
// R1 - Reset clears the register; carry flag value after reset is unspecified
// R2 - Standby entry or exit leaves register contents unchanged
// R3 - Software avoids read-modify-write on this register
// R4 - Software writes the carry flag before relying on it
// R5 - Carry flag sets on any subsecond or seconds count-up
// R6 - Carry flag also sets when a carry meets a counter read
// R7 - Software rereads a counter when carry flag was found set
// R8 - Writing 0 clears the carry flag, writing 1 sets it
// R9 - Carry interrupt requested only while carry flag and enable are 1
// R10 - Alarm interrupt requested only while alarm flag and enable are 1
// R11 - Alarm flag sets on match of enabled fields, year if enabled
// R12 - Writing 0 clears alarm flag, writing 1 leaves it unchanged
// R13 - Reserved bits 6, 5, 2, 1 read zero; software writes zero
// R14 - Only fields with enable bits set take part in the alarm match
// R15 - Interrupt requests are levels of flag AND enable until cleared
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
module rcc_ctrl1
  import rcc_pkg::*;
(
  // Clock and resets
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        manual_reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Clock counters and alarm setting
  input  rcc_cnt_s         cnt,
  input  rcc_cal_s         cal,
  input  rcc_alarm_s       alarm,
  // Interrupt requests
  output logic             carry_irq,
  output logic             alarm_irq,
  output logic             irq
);

  typedef struct packed {
    rcc_ctrl1_s          ctrl1;
    logic [RCC_EV_W-1:0] istat;
    logic [RCC_EV_W-1:0] imask;
    logic                match_q;
    logic [31:0]         rdata;
    logic                carry_irq;
    logic                alarm_irq;
  } rcc_state_s;

  localparam rcc_state_s RCC_STATE_RST = '{
    ctrl1:     rcc_ctrl1_s'(4'h0),
    istat:     RCC_EV_RST,
    imask:     RCC_EV_RST,
    match_q:   1'b0,
    rdata:     32'h0000_0000,
    carry_irq: 1'b0,
    alarm_irq: 1'b0
  };

  rcc_state_s st_r;
  rcc_state_s st_nxt;

  logic match;
  logic carry_evt;
  logic carry_in_read;

  rcc_alarm_match u_alarm_match (
    .cal   (cal),
    .alarm (alarm),
    .match (match)
  );

  rcc_carry_detect u_carry_detect (
    .cnt           (cnt),
    .carry_evt     (carry_evt),
    .carry_in_read (carry_in_read)
  );

  // Address decode, shared by read and write paths
  function automatic logic reg_hit(input logic [11:0] addr,
                                   input logic [11:0] off);
    reg_hit = (addr == off);
  endfunction

  function automatic logic addr_ok(input logic [11:0] addr);
    addr_ok = reg_hit(addr, RCC_OFF_CTRL1) ||
              reg_hit(addr, RCC_OFF_ISTAT) ||
              reg_hit(addr, RCC_OFF_IMASK) ||
              reg_hit(addr, RCC_OFF_MATCH);
  endfunction

  // Packs the control register into its byte, reserved bits at zero
  function automatic logic [7:0] ctrl1_byte(input rcc_ctrl1_s c);
    logic [7:0] b;
    b = 8'h00;                                                   // R13
    b[RCC_BIT_CF]  = c.carry_flag;
    b[RCC_BIT_CIE] = c.carry_irq_enable;
    b[RCC_BIT_AIE] = c.alarm_irq_enable;
    b[RCC_BIT_AF]  = c.alarm_flag;
    ctrl1_byte = b;
  endfunction

  logic       setup;
  logic       access;
  logic       wr;
  logic       wr_ctrl1;
  logic       wr_istat;
  logic       wr_imask;
  logic       match_rise;
  logic [RCC_EV_W-1:0] ev;
  logic [31:0] rd_val;

  always_comb begin
    setup    = psel && !penable;
    access   = psel && penable;
    wr       = access && pwrite && addr_ok(paddr);
    wr_ctrl1 = wr && reg_hit(paddr, RCC_OFF_CTRL1) && pstrb[0];
    wr_istat = wr && reg_hit(paddr, RCC_OFF_ISTAT) && pstrb[0];
    wr_imask = wr && reg_hit(paddr, RCC_OFF_IMASK) && pstrb[0];

    // The flag is raised as the match begins, so a clear sticks
    match_rise = match && !st_r.match_q;

    ev               = '0;
    ev[RCC_EV_CARRY] = carry_evt;
    ev[RCC_EV_ALARM] = match_rise;
    ev[RCC_EV_RDCOL] = carry_in_read;

    // Read data is captured in the setup phase
    if (reg_hit(paddr, RCC_OFF_CTRL1)) begin
      rd_val = {24'h000000, ctrl1_byte(st_r.ctrl1)};
    end else if (reg_hit(paddr, RCC_OFF_ISTAT)) begin
      rd_val = {29'h0, st_r.istat};
    end else if (reg_hit(paddr, RCC_OFF_IMASK)) begin
      rd_val = {29'h0, st_r.imask};
    end else if (reg_hit(paddr, RCC_OFF_MATCH)) begin
      rd_val = {31'h0, match};
    end else begin
      rd_val = 32'h0000_0000;
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.match_q = match;

    // Nothing here reacts to standby, so contents are held across it
    if (manual_reset) begin
      st_nxt.ctrl1 = rcc_ctrl1_s'(4'h0);                         // R1
    end else begin
      // Carry flag: software value, then hardware set on top
      if (wr_ctrl1) begin
        st_nxt.ctrl1.carry_flag       = pwdata[RCC_BIT_CF];      // R8
        st_nxt.ctrl1.carry_irq_enable = pwdata[RCC_BIT_CIE];
        st_nxt.ctrl1.alarm_irq_enable = pwdata[RCC_BIT_AIE];
        if (!pwdata[RCC_BIT_AF]) begin
          st_nxt.ctrl1.alarm_flag = 1'b0;                        // R12
        end
      end
      if (carry_evt) begin
        st_nxt.ctrl1.carry_flag = 1'b1;                          // R5 R6
      end
      if (match_rise) begin
        st_nxt.ctrl1.alarm_flag = 1'b1;                          // R11
      end
    end

    // Sticky event status, write one to clear, events win over clears
    if (wr_istat) begin
      st_nxt.istat = st_r.istat & ~pwdata[RCC_EV_W-1:0];
    end
    st_nxt.istat = st_nxt.istat | ev;
    if (wr_imask) begin
      st_nxt.imask = pwdata[RCC_EV_W-1:0];
    end

    if (setup) begin
      st_nxt.rdata = rd_val;
    end

    st_nxt.carry_irq = st_nxt.ctrl1.carry_flag &&
                       st_nxt.ctrl1.carry_irq_enable;            // R9 R15
    st_nxt.alarm_irq = st_nxt.ctrl1.alarm_flag &&
                       st_nxt.ctrl1.alarm_irq_enable;            // R10 R15
  end

  // No standby term: the register keeps its value whatever the mode // R2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= RCC_STATE_RST;                                     // R1
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    pready    = 1'b1;
    pslverr   = access && !addr_ok(paddr);
    prdata    = st_r.rdata;
    carry_irq = st_r.carry_irq;
    alarm_irq = st_r.alarm_irq;
    irq       = |(st_r.istat & st_r.imask);
  end

endmodule
